// ### core/timer_pkg.sv
package timer_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned UNIT2_W = 16;
	localparam int unsigned UNIT3_W = 8;
	localparam int unsigned PRESC_W = 8;
	localparam int unsigned SEL_W = 3;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CMP2_LO = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CMP2_HI = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CNT2 = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_CTRL3 = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_CMP3 = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_CNT3 = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h20;

	// unit 2 control fields
	localparam int unsigned C2_MODE_LSB = 0;
	localparam int unsigned C2_EDGE_BIT = 2;
	localparam int unsigned C2_EN_BIT = 3;
	localparam int unsigned C2_SEL_LSB = 4;
	// unit 3 control fields
	localparam int unsigned C3_MODE_LSB = 0;
	localparam int unsigned C3_START_BIT = 2;
	localparam int unsigned C3_SEL_LSB = 3;
	localparam int unsigned C3_FF_VAL_BIT = 6;
	localparam int unsigned C3_FF_LOAD_BIT = 7;
	// flip-flop state shown above the unit 3 count
	localparam int unsigned CNT3_FF_BIT = 8;
	// interrupt bits
	localparam int unsigned IRQ_U2_BIT = 0;
	localparam int unsigned IRQ_U3_BIT = 1;
	localparam int unsigned IRQ_W = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [UNIT3_W-1:0] UNIT3_ALL_ONES = 8'hff;

	typedef enum logic [1:0] {U2_TIMER, U2_COUNTER, U2_WINDOW} unit2_mode_t;
	typedef enum logic [1:0] {U3_TIMER, U3_COUNTER, U3_DIVIDER, U3_PULSE_WIDTH} unit3_mode_t;
endpackage

// ### core/dual_match_timer.sv
`timescale 1ns/10ps
module dual_match_timer import timer_pkg::*; (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [DATA_W/8-1:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic [2:0] i_arprot,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_unit2_count_pin,
	input wire logic i_unit3_count_pin,
	output logic o_divider_output_pin_n,
	output logic o_pulse_width_pin_n,
	output logic o_irq
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic [PRESC_W-1:0] presc;
		unit2_mode_t mode2;
		logic edge2;
		logic en2;
		logic [SEL_W-1:0] sel2;
		logic [UNIT2_W-1:0] cmp2;
		logic inhibit2;
		logic [UNIT2_W-1:0] cnt2;
		logic p2_s1;
		logic p2_s2;
		logic g2_prev;
		unit3_mode_t mode3;
		logic start3;
		logic [SEL_W-1:0] sel3;
		logic [UNIT3_W-1:0] stage3;
		logic [UNIT3_W-1:0] active3;
		logic [UNIT3_W-1:0] cnt3;
		logic ff3;
		logic p3_s1;
		logic p3_s2;
		logic g3_prev;
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic irq;
		logic div_n;
		logic pwm_n;
	} state_t;

	localparam state_t RESET_STATE = '{
		mode2: U2_TIMER,
		mode3: U3_TIMER,
		div_n: 1'b1,
		pwm_n: 1'b1,
		default: '0
	};

	state_t st;
	state_t next_st;
	logic do_wr;
	logic do_rd;
	logic g2;
	logic g3;
	logic tick2;
	logic tick3;
	logic ev2;
	logic ev3;
	logic [UNIT2_W-1:0] inc2;
	logic [UNIT3_W-1:0] inc3;

	// a transfer completes on the edge where our ready meets the master's valid
	assign do_wr = st.awready & i_awvalid & i_wvalid;
	assign do_rd = st.arready & i_arvalid;
	assign inc2 = st.cnt2 + 16'h0001;
	assign inc3 = st.cnt3 + 8'h01;

	always_comb begin
		case (st.mode2)
			U2_TIMER: g2 = st.presc[st.sel2];
			U2_COUNTER: g2 = st.edge2 ? ~st.p2_s2 : st.p2_s2;
			U2_WINDOW: g2 = st.presc[st.sel2] & st.p2_s2;
			default: g2 = 1'b0;
		endcase
		case (st.mode3)
			U3_COUNTER: g3 = st.p3_s2;
			default: g3 = st.presc[st.sel3];
		endcase
	end

	// a mode change can look like one edge; software should stop a unit before switching
	assign tick2 = st.en2 & g2 & ~st.g2_prev;
	assign tick3 = st.start3 & g3 & ~st.g3_prev;

	always_comb begin
		logic [IRQ_W-1:0] clr;
		clr = '0;
		next_st = st;
		ev2 = 1'b0;
		ev3 = 1'b0;

		next_st.presc = st.presc + 8'h01;
		next_st.p2_s1 = i_unit2_count_pin;
		next_st.p2_s2 = st.p2_s1;
		next_st.p3_s1 = i_unit3_count_pin;
		next_st.p3_s2 = st.p3_s1;
		next_st.g2_prev = g2;
		next_st.g3_prev = g3;

		// write channel
		next_st.awready = 1'b0;
		next_st.wready = 1'b0;
		if (!st.awready && !st.bvalid && i_awvalid && i_wvalid) begin
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		if (st.bvalid && i_bready) begin
			next_st.bvalid = 1'b0;
		end

		// unit 2
		if (tick2) begin
			if (!st.inhibit2 && inc2 == st.cmp2) begin
				next_st.cnt2 = '0;
				ev2 = 1'b1;
			end else begin
				next_st.cnt2 = inc2;
			end
		end

		// unit 3; the active stage tracks the written value while stopped
		if (!st.start3) begin
			next_st.active3 = st.stage3;
		end
		if (tick3) begin
			case (st.mode3)
				U3_TIMER, U3_COUNTER: begin
					if (inc3 == st.stage3) begin
						next_st.cnt3 = '0;
						ev3 = 1'b1;
					end else begin
						next_st.cnt3 = inc3;
					end
				end
				U3_DIVIDER: begin
					if (inc3 == st.stage3) begin
						next_st.cnt3 = '0;
						next_st.ff3 = ~st.ff3;
						ev3 = 1'b1;
					end else begin
						next_st.cnt3 = inc3;
					end
				end
				U3_PULSE_WIDTH: begin
					if (st.cnt3 == UNIT3_ALL_ONES) begin
						next_st.cnt3 = '0;
						next_st.ff3 = ~st.ff3;
						next_st.active3 = st.stage3;
						ev3 = 1'b1;
					end else begin
						next_st.cnt3 = inc3;
						if (inc3 == st.active3) begin
							next_st.ff3 = ~st.ff3;
						end
					end
				end
				default: next_st.cnt3 = st.cnt3;
			endcase
		end

		// register writes; all fields sit in byte lane 0
		if (do_wr) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case (i_awaddr)
				ADDR_CTRL2: begin
					if (i_wstrb[0]) begin
						next_st.mode2 = unit2_mode_t'(i_wdata[C2_MODE_LSB +: 2]);
						next_st.edge2 = i_wdata[C2_EDGE_BIT];
						next_st.en2 = i_wdata[C2_EN_BIT];
						next_st.sel2 = i_wdata[C2_SEL_LSB +: SEL_W];
					end
				end
				ADDR_CMP2_LO: begin
					if (i_wstrb[0]) begin
						next_st.cmp2[7:0] = i_wdata[7:0];
						next_st.inhibit2 = 1'b1;
					end
				end
				ADDR_CMP2_HI: begin
					if (i_wstrb[0]) begin
						next_st.cmp2[15:8] = i_wdata[7:0];
						next_st.inhibit2 = 1'b0;
					end
				end
				ADDR_CTRL3: begin
					if (i_wstrb[0]) begin
						next_st.mode3 = unit3_mode_t'(i_wdata[C3_MODE_LSB +: 2]);
						next_st.start3 = i_wdata[C3_START_BIT];
						next_st.sel3 = i_wdata[C3_SEL_LSB +: SEL_W];
						// a preset overrides a toggle landing in the same cycle
						if (i_wdata[C3_FF_LOAD_BIT]) begin
							next_st.ff3 = i_wdata[C3_FF_VAL_BIT];
						end
					end
				end
				ADDR_CMP3: begin
					if (i_wstrb[0]) begin
						next_st.stage3 = i_wdata[UNIT3_W-1:0];
					end
				end
				ADDR_IRQ_STATUS: begin
					if (i_wstrb[0]) begin
						clr = i_wdata[IRQ_W-1:0];
					end
				end
				ADDR_IRQ_MASK: begin
					if (i_wstrb[0]) begin
						next_st.mask = i_wdata[IRQ_W-1:0];
					end
				end
				ADDR_CNT2, ADDR_CNT3: next_st.bresp = RESP_OKAY;
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end

		// set wins over a write-one clear in the same cycle
		next_st.status = (st.status & ~clr) | {ev3, ev2};

		// read channel
		next_st.arready = 1'b0;
		if (!st.arready && !st.rvalid && i_arvalid) begin
			next_st.arready = 1'b1;
		end
		if (st.rvalid && i_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (do_rd) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			case (i_araddr)
				ADDR_CTRL2: begin
					next_st.rdata[C2_MODE_LSB +: 2] = st.mode2;
					next_st.rdata[C2_EDGE_BIT] = st.edge2;
					next_st.rdata[C2_EN_BIT] = st.en2;
					next_st.rdata[C2_SEL_LSB +: SEL_W] = st.sel2;
				end
				ADDR_CMP2_LO: next_st.rdata[7:0] = st.cmp2[7:0];
				ADDR_CMP2_HI: next_st.rdata[7:0] = st.cmp2[15:8];
				ADDR_CNT2: next_st.rdata[UNIT2_W-1:0] = st.cnt2;
				ADDR_CTRL3: begin
					next_st.rdata[C3_MODE_LSB +: 2] = st.mode3;
					next_st.rdata[C3_START_BIT] = st.start3;
					next_st.rdata[C3_SEL_LSB +: SEL_W] = st.sel3;
					next_st.rdata[C3_FF_VAL_BIT] = st.ff3;
				end
				ADDR_CMP3: next_st.rdata[UNIT3_W-1:0] = st.stage3;
				ADDR_CNT3: begin
					next_st.rdata[UNIT3_W-1:0] = st.cnt3;
					next_st.rdata[CNT3_FF_BIT] = st.ff3;
				end
				ADDR_IRQ_STATUS: next_st.rdata[IRQ_W-1:0] = st.status;
				ADDR_IRQ_MASK: next_st.rdata[IRQ_W-1:0] = st.mask;
				default: next_st.rresp = RESP_SLVERR;
			endcase
		end

		// pins idle high outside their own mode
		next_st.irq = |(next_st.status & next_st.mask);
		next_st.div_n = (next_st.mode3 == U3_DIVIDER) ? ~next_st.ff3 : 1'b1;
		next_st.pwm_n = (next_st.mode3 == U3_PULSE_WIDTH) ? ~next_st.ff3 : 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign o_awready = st.awready;
	assign o_wready = st.wready;
	assign o_bvalid = st.bvalid;
	assign o_bresp = st.bresp;
	assign o_arready = st.arready;
	assign o_rvalid = st.rvalid;
	assign o_rdata = st.rdata;
	assign o_rresp = st.rresp;
	assign o_divider_output_pin_n = st.div_n;
	assign o_pulse_width_pin_n = st.pwm_n;
	assign o_irq = st.irq;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence lo_wr_s;
		do_wr && i_awaddr == ADDR_CMP2_LO && i_wstrb[0];
	endsequence
	sequence hi_wr_s;
		do_wr && i_awaddr == ADDR_CMP2_HI && i_wstrb[0];
	endsequence
	sequence pwm_wrap_s;
		tick3 && st.mode3 == U3_PULSE_WIDTH && st.cnt3 == UNIT3_ALL_ONES;
	endsequence

	u2_match_clear_a: assert property (
		(tick2 && st.mode2 == U2_TIMER && !st.inhibit2 && inc2 == st.cmp2)
		|=> (st.cnt2 == '0 && st.status[IRQ_U2_BIT]))
		else $error("unit 2 match did not clear and flag");

	u2_count_edge_a: assert property (
		(st.mode2 == U2_COUNTER && st.en2)
		|-> (tick2 == (st.edge2 ? (~st.p2_s2 & ~st.g2_prev) : (st.p2_s2 & ~st.g2_prev))))
		else $error("unit 2 counted off the selected edge");

	u2_window_gate_a: assert property (
		(st.mode2 == U2_WINDOW && !st.p2_s2) |-> !tick2 ##1 $stable(st.cnt2))
		else $error("unit 2 counted with window closed");

	u2_inhibit_hold_a: assert property (
		lo_wr_s ##1 (!(do_wr && i_awaddr == ADDR_CMP2_HI && i_wstrb[0]))[*2]
		|-> st.inhibit2 && !ev2)
		else $error("compare active before high byte written");

	u2_inhibit_release_a: assert property (
		hi_wr_s |=> !st.inhibit2) else $error("compare still held after high byte");

	u3_div_toggle_a: assert property (
		(tick3 && st.mode3 == U3_DIVIDER && inc3 == st.stage3)
		|=> (st.ff3 != $past(st.ff3) && st.cnt3 == '0 && st.status[IRQ_U3_BIT]))
		else $error("divider match did not toggle and clear");

	div_pin_a: assert property (
		(st.mode3 == U3_DIVIDER) |-> (o_divider_output_pin_n == !st.ff3))
		else $error("divider pin not the inverse of flip-flop");

	ff_preset_a: assert property (
		(do_wr && i_awaddr == ADDR_CTRL3 && i_wstrb[0] && i_wdata[C3_FF_LOAD_BIT])
		|=> (st.ff3 == $past(i_wdata[C3_FF_VAL_BIT])))
		else $error("flip-flop preset not taken");

	pwm_overflow_a: assert property (
		pwm_wrap_s |=> (st.cnt3 == '0 && st.ff3 != $past(st.ff3) && st.status[IRQ_U3_BIT]))
		else $error("overflow did not clear, toggle and flag");

	pwm_buffer_a: assert property (
		(st.start3 && st.mode3 == U3_PULSE_WIDTH && !(tick3 && st.cnt3 == UNIT3_ALL_ONES))
		|=> $stable(st.active3))
		else $error("active compare changed mid-period");

	pwm_pin_a: assert property (
		(st.mode3 == U3_PULSE_WIDTH) |-> (o_pulse_width_pin_n == !st.ff3))
		else $error("pulse width pin not the inverse of flip-flop");

	irq_level_a: assert property (
		(tick2 && ev2 && st.mask[IRQ_U2_BIT]) |=> o_irq ##1 (o_irq || !st.status[IRQ_U2_BIT]))
		else $error("unmasked event did not raise interrupt");
endmodule

// ### dv/pin_model.sv
`timescale 1ns/10ps
// far-side count and gate source: a square wave, or a held level while half is 0
module pin_model (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_half,
	input wire logic i_level,
	output logic o_pin
);
	logic [7:0] cnt;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt <= 8'h00;
			o_pin <= 1'b0;
		end else if (i_half == 8'h00) begin
			cnt <= 8'h00;
			o_pin <= i_level;
		end else if (cnt + 8'h01 >= i_half) begin
			// half period kept well above the tick so a gate stays slower than it
			cnt <= 8'h00;
			o_pin <= ~o_pin;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
module tb;
	import timer_pkg::*;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_awvalid = 1'b0;
	logic i_wvalid = 1'b0;
	logic i_bready = 1'b0;
	logic i_arvalid = 1'b0;
	logic i_rready = 1'b0;
	logic [ADDR_W-1:0] i_awaddr = 8'h00;
	logic [ADDR_W-1:0] i_araddr = 8'h00;
	logic [DATA_W-1:0] i_wdata = 32'h0;
	logic [7:0] half2 = 8'h00;
	logic [7:0] half3 = 8'h00;
	logic lvl2 = 1'b0;
	logic lvl3 = 1'b0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	logic pin2, pin3, div_n, pw_n;
	logic [1:0] o_bresp, o_rresp;
	logic [DATA_W-1:0] o_rdata;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #50 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;

	dual_match_timer DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(i_awvalid),
		.o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid),
		.o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hf), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.i_araddr(i_araddr), .i_arprot(3'h0), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .i_unit2_count_pin(pin2),
		.i_unit3_count_pin(pin3), .o_divider_output_pin_n(div_n),
		.o_pulse_width_pin_n(pw_n), .o_irq(o_irq));
	pin_model u2_pin (.i_clk(i_clk), .i_nrst(i_nrst), .i_half(half2), .i_level(lvl2),
		.o_pin(pin2));
	pin_model u3_pin (.i_clk(i_clk), .i_nrst(i_nrst), .i_half(half3), .i_level(lvl3),
		.o_pin(pin3));

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		bit aw;
		bit w;
		n = 0;
		aw = 0;
		w = 0;
		i_awaddr <= a;
		i_wdata <= {24'h0, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (!(aw && w) && n < 40) begin
			@(posedge i_clk);
			n++;
			if (o_awready === 1'b1) begin
				aw = 1;
				i_awvalid <= 1'b0;
			end
			if (o_wready === 1'b1) begin
				w = 1;
				i_wvalid <= 1'b0;
			end
		end
		while (o_bvalid !== 1'b1 && n < 40) begin
			@(posedge i_clk);
			n++;
		end
		i_bready <= 1'b0;
		chk(32'(n < 40), 32'h1, "write done");
		chk(32'(o_bresp), 32'(er), "bresp");
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		while (o_arready !== 1'b1 && n < 40) begin
			@(posedge i_clk);
			n++;
		end
		i_arvalid <= 1'b0;
		while (o_rvalid !== 1'b1 && n < 40) begin
			@(posedge i_clk);
			n++;
		end
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
		chk(32'(n < 40), 32'h1, "read done");
		@(posedge i_clk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp, what);
		chk(32'(r), 32'(RESP_OKAY), "rresp");
	endtask

	function automatic logic sig(input int s);
		return s == 0 ? o_irq : (s == 1 ? div_n : pw_n);
	endfunction

	// waits for the level to leave and come back, giving the cycle of arrival
	task automatic at(input int s, input logic v, output int t);
		int n;
		n = 0;
		while (sig(s) !== ~v && n < 3000) begin
			@(posedge i_clk);
			n++;
		end
		while (sig(s) !== v && n < 3000) begin
			@(posedge i_clk);
			n++;
		end
		t = cyc;
		chk(32'(n < 3000), 32'h1, "wait level");
	endtask

	// clears happen right after an event, so they never meet the next one
	task automatic irq_gap(input int exp, input string what);
		int t0;
		int t1;
		wr(ADDR_IRQ_STATUS, 8'h03, RESP_OKAY);
		at(0, 1'b1, t0);
		wr(ADDR_IRQ_STATUS, 8'h03, RESP_OKAY);
		at(0, 1'b1, t1);
		chk(t1 - t0, exp, what);
	endtask

	task automatic rst;
		half2 <= 8'h00;
		half3 <= 8'h00;
		lvl2 <= 1'b0;
		lvl3 <= 1'b0;
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		wr(ADDR_IRQ_MASK, 8'h03, RESP_OKAY);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rst;
		rdchk(ADDR_CTRL3, 32'h0, "ctrl3 reset");
		rdchk(ADDR_CNT3, 32'h0, "flip-flop reset");
		rdchk(ADDR_IRQ_MASK, 32'h3, "mask");
		chk(32'({o_irq, div_n, pw_n}), 32'h3, "idle pins");
		rd(8'h40, d, r);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
		wr(8'h44, 8'h01, RESP_SLVERR);
	endtask

	task automatic t_u2_timer;
		logic [31:0] d;
		logic [1:0] r;
		rst;
		wr(ADDR_CMP2_LO, 8'd20, RESP_OKAY);
		wr(ADDR_CMP2_HI, 8'h00, RESP_OKAY);
		wr(ADDR_CTRL2, 8'h08, RESP_OKAY);
		irq_gap(40, "u2 timer period");
		rd(ADDR_CNT2, d, r);
		chk(32'(d < 20), 32'h1, "u2 cleared");
		wr(ADDR_CMP2_LO, 8'd60, RESP_OKAY);
		wr(ADDR_IRQ_STATUS, 8'h03, RESP_OKAY);
		repeat (200) @(posedge i_clk);
		rdchk(ADDR_IRQ_STATUS, 32'h0, "match held off");
	endtask

	task automatic t_u2_count;
		rst;
		wr(ADDR_CMP2_LO, 8'd3, RESP_OKAY);
		wr(ADDR_CMP2_HI, 8'h00, RESP_OKAY);
		// mode switched while stopped so the edge detector settles before enable
		wr(ADDR_CTRL2, 8'h05, RESP_OKAY);
		wr(ADDR_CTRL2, 8'h0d, RESP_OKAY);
		lvl2 <= 1'b1;
		repeat (10) @(posedge i_clk);
		rdchk(ADDR_CNT2, 32'h0, "rise ignored");
		lvl2 <= 1'b0;
		repeat (10) @(posedge i_clk);
		rdchk(ADDR_CNT2, 32'h1, "one fall one count");
		half2 <= 8'd10;
		irq_gap(60, "u2 count period");
	endtask

	task automatic t_u2_window;
		logic [31:0] d;
		logic [1:0] r;
		rst;
		wr(ADDR_CMP2_LO, 8'd25, RESP_OKAY);
		wr(ADDR_CMP2_HI, 8'h00, RESP_OKAY);
		wr(ADDR_CTRL2, 8'h0a, RESP_OKAY);
		repeat (40) @(posedge i_clk);
		rdchk(ADDR_CNT2, 32'h0, "gate closed");
		lvl2 <= 1'b1;
		repeat (40) @(posedge i_clk);
		lvl2 <= 1'b0;
		repeat (10) @(posedge i_clk);
		rd(ADDR_CNT2, d, r);
		chk(32'(d >= 18 && d <= 21), 32'h1, "gated count");
		lvl2 <= 1'b1;
		repeat (20) @(posedge i_clk);
		lvl2 <= 1'b0;
		rdchk(ADDR_IRQ_STATUS, 32'h1, "window match");
	endtask

	task automatic t_u3_timer;
		rst;
		wr(ADDR_CMP3, 8'd20, RESP_OKAY);
		wr(ADDR_CTRL3, 8'h04, RESP_OKAY);
		irq_gap(40, "u3 timer period");
	endtask

	task automatic t_u3_count;
		rst;
		wr(ADDR_CMP3, 8'd4, RESP_OKAY);
		wr(ADDR_CTRL3, 8'h05, RESP_OKAY);
		half3 <= 8'd10;
		irq_gap(80, "u3 count period");
	endtask

	task automatic t_div;
		int t0;
		int t1;
		int t2;
		rst;
		wr(ADDR_CTRL3, 8'hc2, RESP_OKAY);
		rdchk(ADDR_CNT3, 32'h100, "preset");
		chk(32'(div_n), 32'h0, "pin inverse");
		wr(ADDR_CMP3, 8'd10, RESP_OKAY);
		wr(ADDR_CTRL3, 8'h06, RESP_OKAY);
		at(1, 1'b1, t0);
		at(1, 1'b0, t1);
		at(1, 1'b1, t2);
		chk(t1 - t0, 20, "div high");
		chk(t2 - t1, 20, "div low");
		chk(32'(pw_n), 32'h1, "pw idle");
		irq_gap(20, "irq per toggle");
	endtask

	task automatic t_pwm;
		int t0;
		int t1;
		int t2;
		rst;
		wr(ADDR_CMP3, 8'h40, RESP_OKAY);
		wr(ADDR_CTRL3, 8'h07, RESP_OKAY);
		at(2, 1'b0, t0);
		wr(ADDR_CMP3, 8'h80, RESP_OKAY);
		at(2, 1'b1, t1);
		at(2, 1'b0, t2);
		chk(t1 - t0, 384, "old width kept");
		chk(t2 - t1, 256, "new width");
		chk(32'(div_n), 32'h1, "div idle");
		irq_gap(512, "irq per overflow");
	endtask

	initial begin
		repeat (60000) @(posedge i_clk);
		bad_count++;
		$display("mismatch at %0t: watchdog", $time);
		results;
	end

	initial begin
		t_reset;
		t_u2_timer;
		t_u2_count;
		t_u2_window;
		t_u3_timer;
		t_u3_count;
		t_div;
		t_pwm;
		results;
	end
endmodule
